// ---- inc/acbsc_cfg.svh ----
`ifndef ACBSC_CFG_SVH
`define ACBSC_CFG_SVH
// Command byte target bits
`define ACBSC_SEL_CONV_BIT 7
`define ACBSC_SEL_SETUP_BIT 6
`define ACBSC_SEL_AVG_BIT 5
`define ACBSC_SEL_RST_BIT 4
// Channel select and scan mode fields
`define ACBSC_CHAN_MSB 6
`define ACBSC_CHAN_LSB 3
`define ACBSC_SCAN_MSB 2
`define ACBSC_SCAN_LSB 1
// Setup fields
`define ACBSC_TMODE_MSB 5
`define ACBSC_TMODE_LSB 4
`define ACBSC_VREF_MSB 3
`define ACBSC_VREF_LSB 2
// Averaging fields
`define ACBSC_AVGEN_BIT 4
`define ACBSC_NAVG_MSB 3
`define ACBSC_NAVG_LSB 2
`define ACBSC_NREP_MSB 1
`define ACBSC_NREP_LSB 0
// Reset control bit
`define ACBSC_RSTCTL_BIT 3
// Power-up values
`define ACBSC_CONV_RST 8'h00
`define ACBSC_SETUP_RST 8'h20
`define ACBSC_AVG_RST 8'h00
// Serial clock limit for external timing mode, in kHz
`define ACBSC_EXT_SCLK_MAX_KHZ 4800
`endif

// ---- inc/acbsc_pkg.sv ----
package acbsc_pkg;
  typedef enum logic [1:0] {
    ACBSC_ST_IDLE = 2'b00,
    ACBSC_ST_RUN  = 2'b01,
    ACBSC_ST_WAIT = 2'b10
  } acbsc_seq_t;

  // Serial and conversion start pin group after synchronising
  typedef struct packed {
    logic [2:0] cs_n;
    logic [2:0] sclk;
    logic [2:0] din;
    logic [2:0] cnv_n;
  } acbsc_sync_t;

  typedef struct packed {
    logic       conv_req;
    logic [3:0] chan;
    logic       chan_skip;
    logic [5:0] sample_cnt;
    logic       result_valid;
    logic [3:0] result_chan;
    logic       fifo_clear;
    logic       scan_done;
    logic       scan_busy;
    logic       vref_on;
  } acbsc_out_t;

  typedef struct packed {
    acbsc_sync_t sy;
    logic [7:0]  shift;
    logic [2:0]  bitcnt;
    logic [7:0]  conv_reg;
    logic [7:0]  setup_reg;
    logic [7:0]  avg_reg;
    acbsc_seq_t  seq;
    logic [3:0]  cur_chan;
    logic [3:0]  last_chan;
    logic [4:0]  res_left;
    logic [5:0]  samp_left;
    acbsc_out_t  o;
  } acbsc_state_t;
endpackage

// ---- rtl/acbsc_core.sv ----
`timescale 1ns/1ps
`include "acbsc_cfg.svh"
module acbsc_core #(
  parameter int unsigned CHANNELS = 16
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       cs_n_pin,
  input  wire logic       sclk_pin,
  input  wire logic       din_pin,
  input  wire logic       conv_start_n,
  input  wire logic       conv_ack,
  output logic            conv_req,
  output logic [3:0]      conv_chan,
  output logic            conv_skip,
  output logic [5:0]      conv_samples,
  output logic            result_valid,
  output logic [3:0]      result_chan,
  output logic            fifo_clear,
  output logic            scan_done,
  output logic            scan_busy,
  output logic            vref_on,
  output logic [1:0]      timing_mode,
  output logic [1:0]      vref_mode,
  output logic            shared_pin_is_start
);

  localparam logic [3:0] TOP_CHAN = 4'(CHANNELS - 1);

  acbsc_pkg::acbsc_state_t s_q;
  acbsc_pkg::acbsc_state_t s_d;

  // Conversions per result from averaging settings
  function automatic logic [5:0] samples_per_result(input logic [7:0] avg, input logic [1:0] tmode);
    logic [5:0] n;
    n = 6'h01;
    if (tmode == 2'b11) begin
      n = 6'h01;
    end else if (!avg[`ACBSC_AVGEN_BIT]) begin
      n = 6'h01;
    end else begin
      case (avg[`ACBSC_NAVG_MSB:`ACBSC_NAVG_LSB])
        2'b00:   n = 6'h04;
        2'b01:   n = 6'h08;
        2'b10:   n = 6'h10;
        default: n = 6'h20;
      endcase
    end
    return n;
  endfunction

  // True when the channel is the one taken by the start pin
  function automatic logic chan_is_start(input logic [3:0] ch, input logic [1:0] tmode);
    return (tmode[1] == 1'b0) && (ch == TOP_CHAN) && (CHANNELS > 4);
  endfunction

  logic       sclk_rise;
  logic       cs_fall;
  logic       cs_low;
  logic       cnv_fall;
  logic       din_bit;
  logic [7:0] byte_in;
  logic       byte_done;
  logic       start_scan;
  logic [1:0] scan_kind;
  logic [3:0] n_chan;
  logic [4:0] n_results;
  logic [3:0] first_chan;
  logic [3:0] stop_chan;
  // Full reset seen this cycle, applied after the sequencer so nothing overrides it
  logic       full_rst;

  always_comb begin
    s_d = s_q;
    // Only stages 1 and 2 are compared; stage 0 feeds stage 1 alone
    s_d.sy.cs_n  = {s_q.sy.cs_n[1:0], cs_n_pin};
    s_d.sy.sclk  = {s_q.sy.sclk[1:0], sclk_pin};
    s_d.sy.din   = {s_q.sy.din[1:0], din_pin};
    s_d.sy.cnv_n = {s_q.sy.cnv_n[1:0], conv_start_n};
    cs_low    = (s_q.sy.cs_n[2] == 1'b0) && (s_q.sy.cs_n[1] == 1'b0);
    cs_fall   = (s_q.sy.cs_n[2] == 1'b1) && (s_q.sy.cs_n[1] == 1'b0);
    sclk_rise = (s_q.sy.sclk[2] == 1'b0) && (s_q.sy.sclk[1] == 1'b1);
    cnv_fall  = (s_q.sy.cnv_n[2] == 1'b1) && (s_q.sy.cnv_n[1] == 1'b0);
    din_bit   = s_q.sy.din[1];
    byte_in   = {s_q.shift[6:0], din_bit};
    byte_done = 1'b0;
    start_scan = 1'b0;
    full_rst  = 1'b0;
    s_d.o.result_valid = 1'b0;
    s_d.o.fifo_clear   = 1'b0;
    s_d.o.scan_done    = 1'b0;

    if (cs_fall) begin
      s_d.bitcnt = 3'h0;
    end else if (cs_low && sclk_rise) begin
      s_d.shift  = byte_in;
      s_d.bitcnt = s_q.bitcnt + 3'h1;
      byte_done  = (s_q.bitcnt == 3'h7);
    end

    if (byte_done) begin
      if (byte_in[`ACBSC_SEL_CONV_BIT]) begin
        s_d.conv_reg = byte_in;
        start_scan = s_q.setup_reg[`ACBSC_TMODE_MSB];
      end else if (byte_in[`ACBSC_SEL_SETUP_BIT]) begin
        s_d.setup_reg = {byte_in[7:2], 2'b00};
      end else if (byte_in[`ACBSC_SEL_AVG_BIT]) begin
        s_d.avg_reg = byte_in;
      end else if (byte_in[`ACBSC_SEL_RST_BIT]) begin
        s_d.o.fifo_clear = 1'b1;
        if (!byte_in[`ACBSC_RSTCTL_BIT]) begin
          s_d.conv_reg  = `ACBSC_CONV_RST;
          s_d.setup_reg = `ACBSC_SETUP_RST;
          s_d.avg_reg   = `ACBSC_AVG_RST;
          // Sequencer abort is applied after the state case below
          full_rst      = 1'b1;
        end
      end
    end

    if (!s_q.setup_reg[`ACBSC_TMODE_MSB] && cnv_fall) begin
      start_scan = 1'b1;
    end
    // A start in the same cycle as a full reset is dropped
    if (full_rst) begin
      start_scan = 1'b0;
    end

    // Newly written byte counts if the start is from the serial side
    scan_kind = s_d.conv_reg[`ACBSC_SCAN_MSB:`ACBSC_SCAN_LSB];
    n_chan    = s_d.conv_reg[`ACBSC_CHAN_MSB:`ACBSC_CHAN_LSB];
    n_results = {1'b0, s_d.avg_reg[`ACBSC_NREP_MSB:`ACBSC_NREP_LSB], 2'b00} + 5'h04;
    first_chan = n_chan;
    stop_chan  = n_chan;
    case (scan_kind)
      2'b00: begin
        first_chan = 4'h0;
        stop_chan  = n_chan;
        n_results  = 5'(n_chan) + 5'h01;
      end
      2'b01: begin
        first_chan = n_chan;
        stop_chan  = TOP_CHAN;
        n_results  = 5'(TOP_CHAN) - 5'(n_chan) + 5'h01;
      end
      2'b10: begin
        first_chan = n_chan;
        stop_chan  = n_chan;
      end
      default: begin
        n_results = 5'h01;
      end
    endcase
    // Scan and repeat forced off in external clock mode
    if (s_d.setup_reg[`ACBSC_TMODE_MSB:`ACBSC_TMODE_LSB] == 2'b11) begin
      first_chan = n_chan;
      stop_chan  = n_chan;
      n_results  = 5'h01;
    end

    case (s_q.seq)
      acbsc_pkg::ACBSC_ST_IDLE: begin
        if (start_scan && s_d.seq == acbsc_pkg::ACBSC_ST_IDLE) begin
          s_d.cur_chan  = first_chan;
          s_d.last_chan = stop_chan;
          s_d.res_left  = n_results;
          s_d.samp_left = samples_per_result(s_d.avg_reg, s_d.setup_reg[`ACBSC_TMODE_MSB:`ACBSC_TMODE_LSB]);
          s_d.seq       = acbsc_pkg::ACBSC_ST_RUN;
          s_d.o.scan_busy = 1'b1;
        end
      end
      acbsc_pkg::ACBSC_ST_RUN: begin
        s_d.o.conv_req   = 1'b1;
        s_d.o.chan       = s_q.cur_chan;
        s_d.o.sample_cnt = s_q.samp_left;
        s_d.o.chan_skip  = chan_is_start(s_q.cur_chan, s_q.setup_reg[`ACBSC_TMODE_MSB:`ACBSC_TMODE_LSB]);
        s_d.seq          = acbsc_pkg::ACBSC_ST_WAIT;
      end
      acbsc_pkg::ACBSC_ST_WAIT: begin
        // A skipped channel finishes without waiting on the converter
        if (conv_ack || s_q.o.chan_skip) begin
          s_d.o.conv_req     = 1'b0;
          s_d.o.result_valid = !s_q.o.chan_skip;
          s_d.o.result_chan  = s_q.cur_chan;
          if (s_q.res_left <= 5'h01) begin
            s_d.seq = acbsc_pkg::ACBSC_ST_IDLE;
            s_d.o.scan_busy = 1'b0;
            s_d.o.scan_done = 1'b1;
          end else begin
            s_d.res_left = s_q.res_left - 5'h01;
            if (s_q.cur_chan != s_q.last_chan) begin
              s_d.cur_chan = s_q.cur_chan + 4'h1;
            end
            s_d.seq = acbsc_pkg::ACBSC_ST_RUN;
          end
        end
      end
      default: begin
        s_d.seq = acbsc_pkg::ACBSC_ST_IDLE;
      end
    endcase

    // full reset aborts scan
    // Placed last so a request raised by the case above cannot survive it;
    // the converter sees its request drop without an acknowledge
    if (full_rst) begin
      s_d.seq         = acbsc_pkg::ACBSC_ST_IDLE;
      s_d.o.conv_req  = 1'b0;
      s_d.o.scan_busy = 1'b0;
    end

    // reference enable
    // Switched reference follows busy, so it wakes with the scan start
    s_d.o.vref_on = (s_d.setup_reg[`ACBSC_VREF_MSB:`ACBSC_VREF_LSB] == 2'b10) ||
                    ((s_d.setup_reg[`ACBSC_VREF_MSB:`ACBSC_VREF_LSB] == 2'b00) && s_d.o.scan_busy);
  end

  // Single state register, constants only under reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.sy        <= '1;
      s_q.setup_reg <= `ACBSC_SETUP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timing_mode         <= 2'b10;
      vref_mode           <= 2'b00;
      shared_pin_is_start <= 1'b0;
    end else begin
      timing_mode         <= s_d.setup_reg[`ACBSC_TMODE_MSB:`ACBSC_TMODE_LSB];
      vref_mode           <= s_d.setup_reg[`ACBSC_VREF_MSB:`ACBSC_VREF_LSB];
      shared_pin_is_start <= !s_d.setup_reg[`ACBSC_TMODE_MSB];
    end
  end

  // Outputs straight from the state flops
  assign conv_req     = s_q.o.conv_req;
  assign conv_chan    = s_q.o.chan;
  assign conv_skip    = s_q.o.chan_skip;
  assign conv_samples = s_q.o.sample_cnt;
  assign result_valid = s_q.o.result_valid;
  assign result_chan  = s_q.o.result_chan;
  assign fifo_clear   = s_q.o.fifo_clear;
  assign scan_done    = s_q.o.scan_done;
  assign scan_busy    = s_q.o.scan_busy;
  assign vref_on      = s_q.o.vref_on;

endmodule // acbsc_core

// ---- bench/acbsc_props.sv ----
`timescale 1ns/1ps
module acbsc_props #(
  parameter int unsigned CHANNELS = 16
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cs_n_pin,
  input wire logic       sclk_pin,
  input wire logic       din_pin,
  input wire logic       conv_start_n,
  input wire logic       conv_ack,
  input wire logic       conv_req,
  input wire logic [3:0] conv_chan,
  input wire logic       conv_skip,
  input wire logic [5:0] conv_samples,
  input wire logic       result_valid,
  input wire logic [3:0] result_chan,
  input wire logic       fifo_clear,
  input wire logic       scan_done,
  input wire logic       scan_busy,
  input wire logic       vref_on,
  input wire logic [1:0] timing_mode,
  input wire logic [1:0] vref_mode,
  input wire logic       shared_pin_is_start
);
  localparam logic [3:0] TOP = 4'(CHANNELS - 1);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Request waiting on, or taking, its acknowledge
  sequence waiting_s;
    conv_req && !conv_skip && !conv_ack;
  endsequence
  sequence acked_s;
    conv_req && !conv_skip && conv_ack;
  endsequence
  pin_role_a: assert property (shared_pin_is_start == !timing_mode[1])
    else $error("shared pin role mismatch");
  skip_top_a: assert property (conv_req && conv_skip |-> shared_pin_is_start && conv_chan == TOP)
    else $error("skip on wrong channel");
  no_false_a: assert property (conv_req && shared_pin_is_start && conv_chan == TOP |-> conv_skip)
    else $error("shared channel converted");
  ext_single_a: assert property (conv_req && timing_mode == 2'b11 |-> conv_samples == 6'h01)
    else $error("averaging in timing mode 11");
  sample_set_a: assert property (conv_req |-> conv_samples inside {6'h01, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("illegal sample count");
  req_holds_a: assert property (waiting_s |=> (conv_req && $stable(conv_chan) && $stable(conv_samples)) || (fifo_clear && !scan_busy))
    else $error("request changed before ack");
  result_follow_a: assert property (acked_s |=> result_valid && result_chan == $past(conv_chan))
    else $error("result missing after ack");
  idle_quiet_a: assert property (!scan_busy |-> !conv_req)
    else $error("request outside a scan");
  start_req_a: assert property ($rose(scan_busy) |-> ##1 conv_req)
    else $error("scan start without request");
  clear_pulse_a: assert property (fifo_clear |=> !fifo_clear)
    else $error("fifo clear longer than a pulse");
  vref_track_a: assert property (vref_on == (vref_mode == 2'b10 || (vref_mode == 2'b00 && scan_busy)))
    else $error("reference enable wrong");
  done_idle_a: assert property (scan_done |-> !scan_busy)
    else $error("scan done while busy");
endmodule // acbsc_props

bind acbsc_core acbsc_props #(.CHANNELS(CHANNELS)) u_props (.*);

// ---- bench/acbsc_host.sv ----
`timescale 1ns/1ps
module acbsc_host (
  input  wire logic clock,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  // Idle: deselected, serial clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clock) #1 cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      din = b[i];
      repeat (4) @(posedge clock);
      #1 sclk = 1'b1;
      repeat (4) @(posedge clock);
      #1 sclk = 1'b0;
    end
    // Released data shows no stale level
    din = ~b[0];
    repeat (4) @(posedge clock);
    #1 cs_n = 1'b1;
    repeat (4) @(posedge clock);
  endtask
endmodule // acbsc_host

// ---- bench/adc_command_byte_scan_control_tb.sv ----
`timescale 1ns/1ps
module adc_command_byte_scan_control_tb;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       conv_start_n = 1'b1;
  logic       conv_ack = 1'b0;
  logic       cs_n_pin, sclk_pin, din_pin, conv_req, conv_skip, result_valid;
  logic       fifo_clear, scan_done, scan_busy, vref_on, shared_pin_is_start;
  logic [3:0] conv_chan, result_chan;
  logic [5:0] conv_samples;
  logic [1:0] timing_mode, vref_mode;
  int         err_count = 0;
  int         comparisons = 0;
  int         cyc = 0;
  int         clears = 0;
  int         dones = 0;
  int         scans = 0;
  int         setup_m = 32;
  int         avg_m = 0;
  int         req_q[$];
  int         res_q[$];

  always #25 clock = ~clock;
  acbsc_host host (.clock(clock), .cs_n(cs_n_pin), .sclk(sclk_pin), .din(din_pin));
  acbsc_core #(.CHANNELS(16)) DUT (.*);

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Expected requests and results of one scan
  task automatic plan(input int c);
    int n, tm, sc, smp, lo, hi, ch, sk;
    scans++;
    n = c >> 3 & 15;
    tm = setup_m >> 4 & 3;
    sc = tm == 3 ? 3 : c >> 1 & 3;
    smp = (avg_m & 16) && tm != 3 ? 4 << (avg_m >> 2 & 3) : 1;
    lo = sc == 0 ? 0 : n;
    hi = sc == 1 ? 15 : sc == 2 ? n + 4 * (avg_m & 3) + 3 : n;
    for (int k = lo; k <= hi; k++) begin
      ch = sc == 2 ? n : k;
      sk = tm < 2 && ch == 15;
      req_q.push_back(sk ? 1024 + ch * 64 : ch * 64 + smp);
      if (!sk)
        res_q.push_back(ch);
    end
  endtask

  // Model register update, then the byte on the wire
  task automatic wr(input int b);
    if (b >= 128 && setup_m >= 32)
      plan(b);
    else if (b >= 64 && b < 128)
      setup_m = b & 60;
    else if (b >= 32 && b < 64)
      avg_m = b & 31;
    else if (b >= 16 && b < 32 && !(b & 8)) begin
      setup_m = 32;
      avg_m = 0;
    end
    host.send(b[7:0]);
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && (req_q.size() || res_q.size() || scan_busy !== 1'b0); i++)
      @(negedge clock);
    chk("left", req_q.size() + res_q.size(), 0);
  endtask

  // Converter stand-in: checks each request, acknowledges each unskipped one after a random wait
  initial forever begin
    @(negedge clock);
    if (conv_req === 1'b1) begin
      chk("request", {conv_skip, conv_chan, conv_skip ? 6'h00 : conv_samples},
          req_q.size() ? req_q.pop_front() : 16'hFFFF);
      if (conv_skip !== 1'b1) begin
        repeat ($urandom_range(3)) @(posedge clock);
        @(posedge clock) #1 conv_ack = 1'b1;
        @(posedge clock) #1 conv_ack = 1'b0;
        @(posedge clock);
      end
    end
  end
  // Result order and clear pulses
  always @(negedge clock) begin
    if (result_valid === 1'b1)
      chk("result_chan", result_chan, res_q.size() ? res_q.pop_front() : 99);
    if (fifo_clear === 1'b1)
      clears++;
    if (scan_done === 1'b1)
      dones++;
  end

  task automatic pulse_start();
    @(posedge clock) #1 conv_start_n = 1'b0;
    repeat (4) @(posedge clock);
    #1 conv_start_n = 1'b1;
  endtask

  initial begin
    void'($urandom(32'h1A8EFE7A));
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    chk("timing_mode", timing_mode, 2);
    chk("vref_mode", vref_mode, 0);
    for (int i = 0; i < 12; i++) begin
      wr(64 + i / 3 * 16 + i % 3 * 4 + 3);
      chk("vref_on", vref_on, i % 3 == 2);
      chk("timing_mode", timing_mode, i / 3);
      chk("vref_mode", vref_mode, i % 3);
      chk("pin_role", shared_pin_is_start, i < 6);
    end
    // Random averaging and scans, mode 11 then mode 10
    for (int i = 0; i < 24; i++) begin
      if (i == 12)
        wr(8'h60);
      wr(32 + $urandom_range(31));
      wr(128 + $urandom_range(127));
      drain();
    end
    // Mode 00: serial start refused, pin start scans 13 up with skip
    wr(8'h40);
    wr(8'hEA);
    chk("busy", scan_busy, 0);
    plan(8'hEA);
    pulse_start();
    drain();
    // Empty target ignored, clear only, then full reset
    wr(8'h0F);
    chk("clears", clears, 0);
    wr(8'h18);
    chk("timing_mode", timing_mode, 0);
    wr(8'h10);
    chk("timing_mode", timing_mode, 2);
    chk("clears", clears, 2);
    pulse_start();
    wr(8'hB4);
    drain();
    // Let the pulse counter settle past the last done pulse
    repeat (2) @(negedge clock);
    chk("scan_done", dones, scans);
    give_verdict();
  end

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule // adc_command_byte_scan_control_tb
